// File: bench/ptmc_pins.sv
// Pin-side model of the periodic timer: drives the capture and external clock pins.
// Assumes the testbench asks for pin levels; the output pin has no pull of its own.
`timescale 1ns/10ps
`default_nettype none
module ptmc_pins
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Requested levels: bit 0 capture pin, bit 1 external clock pin.
    input wire logic [1:0] want,
    output logic capture_input_pin,
    output logic ext_clock_pin,
    // Output pin and the resolved wire.
    input wire logic timer_output_pin,
    input wire logic timer_output_pin_oe,
    output logic out_wire
);
    logic held;
    // Pins move just after a clock edge and stay put until asked again.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            capture_input_pin <= 1'b0;
            ext_clock_pin <= 1'b0;
            held <= 1'b0;
        end
        else
        begin
            capture_input_pin <= want[0];
            ext_clock_pin <= want[1];
            if (timer_output_pin_oe) held <= timer_output_pin;
        end
    end
    // With no keeper a released pin must not look driven, so it shows the opposite level.
    assign out_wire = timer_output_pin_oe ? timer_output_pin : ~held;
endmodule
`default_nettype wire

// File: bench/ptmc_timer_sva.sv
// Checker for the periodic timer: read answers, output enable and forced pin levels.
// Assumes software changes the mode only while the timer is off.
`timescale 1ns/10ps
`default_nettype none
module ptmc_timer_sva
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Register port.
    input wire ptmc_pkg::ptmc_req_t req,
    input wire logic [7:0] rdata,
    // Pins.
    input wire logic count_tick,
    input wire logic capture_input_pin,
    input wire logic ext_clock_pin,
    input wire logic timer_output_pin,
    input wire logic timer_output_pin_oe
);
    logic [7:0] m;
    logic [7:0] per_lo;
    logic [7:0] a_lo;
    logic [1:0] mage;
    logic on_s;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    function automatic logic wr_at(input logic [3:0] a);
        return req.wr && req.addr == a;
    endfunction
    // Shadows of written fields; the age lets the pin settle after a mode write.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            m <= 8'h00;
            mage <= 2'd0;
            per_lo <= 8'h00;
            a_lo <= 8'h00;
            on_s <= 1'b0;
        end
        else
        begin
            mage <= wr_at(ptmc_pkg::OFF_MODE) ? 2'd0 : (mage == 2'd3 ? mage : 2'(mage + 2'd1));
            if (wr_at(ptmc_pkg::OFF_MODE)) m <= req.wdata;
            if (wr_at(ptmc_pkg::OFF_PER_LO)) per_lo <= req.wdata;
            if (wr_at(ptmc_pkg::OFF_CMPA_LO)) a_lo <= req.wdata;
            if (wr_at(ptmc_pkg::OFF_CONTROL)) on_s <= req.wdata[3];
        end
    end
    sequence on_rise_s;
        req.wr && req.addr == ptmc_pkg::OFF_CONTROL && req.wdata[3] && !on_s;
    endsequence
    sequence start_level_s;
        ##3 timer_output_pin == (m[3] ^ m[2]);
    endsequence
    rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
        else $error("read data outside a read answer");
    high_zero_a: assert property ($past(req.rd)
        && $past(req.addr) inside {4'h4, 4'h6, 4'h8, 4'ha} |-> rdata[7:2] == 6'h00)
        else $error("high byte upper bits not zero");
    capclr_zero_a: assert property ($past(req.rd) && $past(req.addr) == ptmc_pkg::OFF_CAPCLR
        |-> rdata[7:3] == 5'h00) else $error("capture clear upper bits not zero");
    unmapped_zero_a: assert property ($past(req.rd) && $past(req.addr) > ptmc_pkg::OFF_PER_HI
        |-> rdata == 8'h00) else $error("unmapped read not zero");
    period_back_a: assert property ($past(req.rd) && $past(req.addr) == ptmc_pkg::OFF_PER_LO
        |-> rdata == $past(per_lo)) else $error("period low readback wrong");
    oe_released_a: assert property (mage == 2'd3 && m[6] |-> !timer_output_pin_oe)
        else $error("pin driven in capture or timer mode");
    oe_driven_a: assert property (mage == 2'd3 && !m[6] |-> timer_output_pin_oe)
        else $error("pin not driven in an output mode");
    pwm_force_a: assert property (mage == 2'd3 && m[7:6] == 2'b10 && !m[5]
        |-> timer_output_pin == ((m[4] ~^ m[3]) ^ m[2])) else $error("forced level wrong");
    init_level_a: assert property (on_rise_s
        ##0 (m[7:6] == 2'b00 && mage == 2'd3 && a_lo > 8'h01) |-> start_level_s)
        else $error("initial level not restored");
endmodule
bind ptmc_timer ptmc_timer_sva i_ptmc_timer_sva (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .count_tick(count_tick), .capture_input_pin(capture_input_pin), .ext_clock_pin(ext_clock_pin),
    .timer_output_pin(timer_output_pin), .timer_output_pin_oe(timer_output_pin_oe));
`default_nettype wire

// File: bench/tb.sv
// Self-checking testbench for the periodic timer block.
// Assumes the pin model beside the block and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb;
    // Counter cases: mode, compare A, period, count modulus.
    localparam int CTAB [4][4] = '{'{8'hc0, 0, 10, 11}, '{8'hc1, 7, 5, 8}, '{8'hc0, 0, 0, 1024}, '{8'h81, 7, 10, 11}};
    // Capture cases: clear code, edge code, source, rising, target (1 A, 2 B).
    localparam logic [7:0] PTAB [7] = '{8'h05, 8'h19, 8'h34, 8'h46, 8'h99, 8'he6, 8'he9};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    ptmc_pkg::ptmc_req_t req = '0;
    logic [7:0] rdata;
    logic count_tick = 1'b0;
    logic [1:0] want = 2'b00;
    logic cap_pin, ext_pin, pin, pin_oe, out_wire;
    logic [7:0] expq [$];
    logic rd_q = 1'b0;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    integer seed = 32'he607a969;
    ptmc_timer i_ptmc_timer (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .count_tick(count_tick),
        .capture_input_pin(cap_pin), .ext_clock_pin(ext_pin), .timer_output_pin(pin), .timer_output_pin_oe(pin_oe));
    ptmc_pins i_ptmc_pins (.clk(clk), .rst_b(rst_b), .want(want), .capture_input_pin(cap_pin),
        .ext_clock_pin(ext_pin), .timer_output_pin(pin), .timer_output_pin_oe(pin_oe), .out_wire(out_wire));
    always #4 clk = ~clk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string what);
        tests_run++;
        if (!ok)
        begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic cyc(input int n);
        req <= '0;
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        expq.push_back(e);
        @(posedge clk);
    endtask
    // Off first, so mode and pin function never change while counting.
    task automatic setup(input logic [7:0] md, input logic [7:0] a, input logic [7:0] p, input logic [7:0] cc);
        wr(ptmc_pkg::OFF_CONTROL, 8'h00);
        wr(ptmc_pkg::OFF_MODE, md);
        wr(ptmc_pkg::OFF_CMPA_LO, a);
        wr(ptmc_pkg::OFF_PER_LO, p);
        wr(ptmc_pkg::OFF_CMPB_LO, 8'h00);
        wr(ptmc_pkg::OFF_CAPCLR, cc);
        wr(ptmc_pkg::OFF_CONTROL, 8'h08);
    endtask
    task automatic run(input int n, output int t);
        logic r;
        req <= '0;
        t = 0;
        // The cycle in which counter_on rises zeroes the counter, so no tick is offered then.
        count_tick <= 1'b0;
        @(posedge clk);
        repeat (n)
        begin
            r = 1'($random(seed));
            count_tick <= r;
            @(posedge clk);
            t += r;
        end
        count_tick <= 1'b0;
    endtask
    // Read answers come one cycle after the strobe, oldest note first.
    always @(posedge clk)
    begin
        if (rd_q)
            chk(rdata === expq.pop_front(), "read data");
        rd_q <= req.rd;
    end
    // A hang is cut short here.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    initial
    begin
        logic [7:0] v;
        logic [7:0] c;
        int t;
        int n;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 16; a++)
            rd(4'(a), 8'h00);
        for (int a = 0; a < 16; a++)
        begin
            v = 8'($random(seed));
            wr(4'(a), a inside {1, 5, 7, 9} ? v : 8'hff);
            c = a inside {6, 8, 10} ? 8'h03 : a == 2 ? 8'h06 : a == 0 ? 8'h08 : 8'h00;
            rd(4'(a), a inside {1, 5, 7, 9} ? v : c);
            wr(4'(a), 8'h00);
        end
        $display("test registers done");
        foreach (CTAB[i])
        begin
            setup(8'(CTAB[i][0]), 8'(CTAB[i][1]), 8'(CTAB[i][2]), 8'h00);
            run(2 * CTAB[i][3] + 20, t);
            wr(ptmc_pkg::OFF_CONTROL, 8'h00);
            n = t % CTAB[i][3];
            rd(ptmc_pkg::OFF_CNT_LO, 8'(n));
            rd(ptmc_pkg::OFF_CNT_HI, 8'(n >> 8));
        end
        $display("test counter done");
        foreach (PTAB[i])
        begin
            c = PTAB[i];
            want <= {2{~c[2]}};
            setup({2'b01, c[5:4], 2'b00, c[3], 1'b0}, 8'h00, 8'h00, {5'h00, c[7:6], 1'b0});
            run(30, t);
            cyc(2);
            want <= c[3] ? {c[2], ~c[2]} : {~c[2], c[2]};
            cyc(6);
            rd(ptmc_pkg::OFF_CMPA_LO, c[1:0] == 2'd1 ? 8'(t) : 8'h00);
            rd(ptmc_pkg::OFF_CMPB_LO, c[1:0] == 2'd2 ? 8'(t) : 8'h00);
            rd(ptmc_pkg::OFF_CNT_LO, (c[7:6] == 2'd3 || c[7:6] == {~c[2], c[2]}) ? 8'h00 : 8'(t));
            if (c[7:6] != 2'd0) rd(ptmc_pkg::OFF_CAPCLR, {5'h00, c[7:6], c[2]});
        end
        $display("test capture done");
        for (int k = 0; k < 16; k++)
        begin
            setup(8'(k * 4), 8'h05, 8'h00, 8'h00);
            count_tick <= 1'b1;
            cyc(3);
            chk(out_wire === 1'(k[1] ^ k[0]), "initial level");
            cyc(12);
            chk(out_wire === 1'((k[3:2] == 0 ? k[1] : k[3:2] == 3 ? !k[1] : k[3]) ^ k[0]),
                "match level");
        end
        $display("test compare done");
        for (int k = 0; k < 12; k++)
        begin
            setup(8'h80 | 8'((k / 4) * 16 + (k % 4) * 4), 8'h03, 8'h09, 8'h00);
            cyc(5);
            n = 0;
            repeat (100)
            begin
                @(posedge clk);
                n += int'(out_wire === 1'(k[1] ^ k[0]));
            end
            chk(n == (k < 4 ? 0 : k < 8 ? 100 : 30), "pwm active cycles");
        end
        $display("test pwm done");
        setup(8'hb8, 8'h06, 8'h00, 8'h00);
        cyc(3);
        chk(out_wire === 1'b1, "pulse start");
        cyc(15);
        chk(out_wire === 1'b0, "pulse end");
        rd(ptmc_pkg::OFF_CONTROL, 8'h00);
        want <= 2'b10;
        cyc(6);
        chk(out_wire === 1'b1, "external pulse start");
        cyc(15);
        chk(out_wire === 1'b0, "external pulse end");
        $display("test pulse done");
        test_done();
    end
endmodule
`default_nettype wire

// File: pkg/ptmc_pkg.sv
// Package for the periodic timer configuration block: register offsets, field positions, modes.
// Assumes an 8-bit register port with one index per register.
package ptmc_pkg;
    // Register offsets; counter_on has its own control register here.
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_MODE = 4'h1;
    localparam logic [3:0] OFF_CAPCLR = 4'h2;
    localparam logic [3:0] OFF_CNT_LO = 4'h3;
    localparam logic [3:0] OFF_CNT_HI = 4'h4;
    localparam logic [3:0] OFF_CMPA_LO = 4'h5;
    localparam logic [3:0] OFF_CMPA_HI = 4'h6;
    localparam logic [3:0] OFF_CMPB_LO = 4'h7;
    localparam logic [3:0] OFF_CMPB_HI = 4'h8;
    localparam logic [3:0] OFF_PER_LO = 4'h9;
    localparam logic [3:0] OFF_PER_HI = 4'ha;
    // Field positions.
    localparam int CTL_ON_BIT = 3;
    localparam int MODE_SEL_LSB = 6;
    localparam int PIN_SEL_LSB = 4;
    localparam int INIT_LVL_BIT = 3;
    localparam int INVERT_BIT = 2;
    localparam int CAP_SRC_BIT = 1;
    localparam int CLR_A_BIT = 0;
    localparam int CAPCLR_LSB = 1;
    localparam int EDGE_FLAG_BIT = 0;
    // Reset values.
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [1:0] CAPCLR_RESET = 2'h0;
    localparam logic [9:0] VAL_RESET = 10'h000;
    localparam logic [9:0] CNT_MAX = 10'h3ff;
    // Operating modes, binary order along the usual path.
    typedef enum logic [1:0]
    {
        PTMC_COMPARE = 2'h0,
        PTMC_CAPTURE = 2'h1,
        PTMC_PWM = 2'h2,
        PTMC_TIMER = 2'h3
    } ptmc_mode_t;
    // Pin function codes.
    localparam logic [1:0] PIN_00 = 2'h0;
    localparam logic [1:0] PIN_01 = 2'h1;
    localparam logic [1:0] PIN_10 = 2'h2;
    localparam logic [1:0] PIN_11 = 2'h3;
    // Register port carrier.
    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ptmc_req_t;
endpackage

// File: rtl/ptmc_timer.sv
// Periodic timer configuration and data registers with a 10-bit counter, compare and capture.
// Assumes synchronous pins and a counter advancing once per count_tick.
//
// Functional notes
// - Mode field: 00 compare, 01 capture, 10 PWM/pulse, 11 timer.
// - Timer mode leaves the output pin undriven and undefined.
// - Compare mode match A: keep, drive low, drive high or toggle.
// - PWM mode pin field: inactive, active, PWM waveform, single pulse.
// - Capture with clear code 00 copies counter into compare A on chosen edges.
// - Capture with clear code nonzero: rising into B, falling into A.
// - Match leaves output unchanged if requested level equals initial level.
// - Rising counter_on restores output to its initial level.
// - Compare mode init level bit gives the pre-match output level.
// - PWM init bit gives active level; pulse mode level at start.
// - Invert bit inverts the output pin outside timer mode.
// - Capture source bit: 0 capture pin, 1 external clock pin.
// - Clear-on-A bit 1 clears on match A, else match P or overflow.
// - Overflow clear only when clear-on-A is 0 and period is zero.
// - Clear-on-A bit is ignored in PWM, pulse and capture modes.
// - Capture clear field adds rising, falling or either trigger edge clears.
// - Read-only edge flag: 1 rising, 0 falling caused last latch.
// - Counter readable as low byte and two-bit high byte.
// - Compare A, B, period are 10-bit byte-pair registers resetting to zero.
// - Unimplemented bits read as zero.
// - Rising counter_on zeroes counter; falling stops and keeps it.
// - PWM: period match clears counter, compare A sets duty.
// - Pulse mode: match A clears counter_on, ending pulse.
`timescale 1ns/10ps
`default_nettype none
module ptmc_timer
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Register port.
    input wire ptmc_pkg::ptmc_req_t req,
    output logic [7:0] rdata,
    // Count rate enable.
    input wire logic count_tick,
    // Pins.
    input wire logic capture_input_pin,
    input wire logic ext_clock_pin,
    output logic timer_output_pin,
    output logic timer_output_pin_oe
);
    logic [7:0] mode_reg;
    logic [1:0] capture_clear_sel;
    logic latch_edge_flag;
    logic counter_on;
    logic on_prev;
    logic [9:0] count;
    logic [9:0] compare_a_value;
    logic [9:0] compare_b_value;
    logic [9:0] period_value;
    logic out_level;
    logic trig_prev;
    logic ext_prev;
    ptmc_pkg::ptmc_mode_t op_mode_sel;
    logic [1:0] pin_function_sel;
    logic output_init_level;
    logic output_invert;
    logic capture_source_sel;
    logic clear_on_match_a;
    logic trig;
    logic trig_rise;
    logic trig_fall;
    logic cap_rise;
    logic cap_fall;
    logic match_a;
    logic match_p;
    logic on_rise;
    logic pulse_mode;
    logic cnt_clear;
    logic [9:0] next_count;
    logic next_pin;

    // Writes into the 10-bit byte pairs; high bytes keep only two bits.
    function automatic logic [9:0] pair_write(input logic [9:0] cur, input logic hi, input logic [7:0] d);
        pair_write = hi ? {d[1:0], cur[7:0]} : {cur[9:2 + 6], d};
    endfunction

    // Field decode of the mode register.
    assign op_mode_sel = ptmc_pkg::ptmc_mode_t'(mode_reg[ptmc_pkg::MODE_SEL_LSB +: 2]);
    assign pin_function_sel = mode_reg[ptmc_pkg::PIN_SEL_LSB +: 2];
    assign output_init_level = mode_reg[ptmc_pkg::INIT_LVL_BIT];
    assign output_invert = mode_reg[ptmc_pkg::INVERT_BIT];
    assign capture_source_sel = mode_reg[ptmc_pkg::CAP_SRC_BIT];
    assign clear_on_match_a = mode_reg[ptmc_pkg::CLR_A_BIT];
    assign pulse_mode = (op_mode_sel == ptmc_pkg::PTMC_PWM) && (pin_function_sel == ptmc_pkg::PIN_11);

    // Trigger edges from the chosen capture pin.
    assign trig = capture_source_sel ? ext_clock_pin : capture_input_pin;
    assign trig_rise = trig && !trig_prev;
    assign trig_fall = !trig && trig_prev;
    assign on_rise = counter_on && !on_prev;
    assign match_a = counter_on && count_tick && (count == compare_a_value);
    // A period of zero stands for the full 1024-count range, so it never matches;
    // otherwise the counter would sit at zero in capture and PWM modes.
    assign match_p = counter_on && count_tick && (period_value != ptmc_pkg::VAL_RESET) && (count == period_value);

    // Capture edges enabled by the pin field; code 11 disables capture.
    always_comb
    begin
        cap_rise = 1'b0;
        cap_fall = 1'b0;
        if (op_mode_sel == ptmc_pkg::PTMC_CAPTURE && counter_on)
        begin
            case (pin_function_sel)
                ptmc_pkg::PIN_00: cap_rise = trig_rise;
                ptmc_pkg::PIN_01: cap_fall = trig_fall;
                ptmc_pkg::PIN_10:
                begin
                    cap_rise = trig_rise;
                    cap_fall = trig_fall;
                end
                default: ;
            endcase
        end
    end

    // Counter clear selection per mode.
    always_comb
    begin
        cnt_clear = 1'b0;
        case (op_mode_sel)
            ptmc_pkg::PTMC_COMPARE, ptmc_pkg::PTMC_TIMER:
                if (clear_on_match_a)
                    cnt_clear = match_a;
                else
                    cnt_clear = (period_value != ptmc_pkg::VAL_RESET) ? match_p : 1'b0;
            ptmc_pkg::PTMC_CAPTURE:
                // Edge clears use the raw trigger so they work whatever capture edges are chosen.
                case (capture_clear_sel)
                    2'h1: cnt_clear = match_p || (counter_on && trig_rise);
                    2'h2: cnt_clear = match_p || (counter_on && trig_fall);
                    2'h3: cnt_clear = match_p || (counter_on && (trig_rise || trig_fall));
                    default: cnt_clear = match_p;
                endcase
            ptmc_pkg::PTMC_PWM:
                cnt_clear = pulse_mode ? 1'b0 : match_p;
            default: cnt_clear = 1'b0;
        endcase
    end

    // Next counter value; wraps naturally at the top, which is the overflow clear.
    // The carry out of the top bit is dropped on purpose.
    always_comb
    begin
        next_count = count;
        if (on_rise)
            next_count = ptmc_pkg::VAL_RESET;
        else if (cnt_clear)
            next_count = ptmc_pkg::VAL_RESET;
        else if (counter_on && count_tick)
            next_count = 10'(count + 10'h001);
    end

    // Counter register.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count <= ptmc_pkg::VAL_RESET;
        else
            count <= next_count;
    end

    // Edge history of pins and of counter_on.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trig_prev <= 1'b0;
            ext_prev <= 1'b0;
            on_prev <= 1'b0;
        end
        else
        begin
            trig_prev <= trig;
            ext_prev <= ext_clock_pin;
            on_prev <= counter_on;
        end
    end

    // Configuration registers; writes to unimplemented bits are dropped.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_reg <= ptmc_pkg::MODE_RESET;
            capture_clear_sel <= ptmc_pkg::CAPCLR_RESET;
        end
        else if (req.wr)
        begin
            if (req.addr == ptmc_pkg::OFF_MODE)
                mode_reg <= req.wdata;
            if (req.addr == ptmc_pkg::OFF_CAPCLR)
                capture_clear_sel <= req.wdata[ptmc_pkg::CAPCLR_LSB +: 2];
        end
    end

    // Counter on bit: software, external pin start in pulse mode, auto stop on match A.
    // The automatic stop outranks a software write in the same cycle,
    // so a pulse can never be stretched past its compare A width.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            counter_on <= 1'b0;
        else if (pulse_mode && match_a)
            counter_on <= 1'b0;
        else if (req.wr && req.addr == ptmc_pkg::OFF_CONTROL)
            counter_on <= req.wdata[ptmc_pkg::CTL_ON_BIT];
        else if (pulse_mode && ext_clock_pin && !ext_prev)
            counter_on <= 1'b1;
    end

    // Compare B is only written by software or by rising-edge captures with edge clear on.
    // A capture wins over a same-cycle software write, so a measurement is never lost.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            compare_b_value <= ptmc_pkg::VAL_RESET;
        else if (cap_rise && capture_clear_sel != ptmc_pkg::CAPCLR_RESET)
            compare_b_value <= count;
        else if (req.wr && (req.addr == ptmc_pkg::OFF_CMPB_LO || req.addr == ptmc_pkg::OFF_CMPB_HI))
            compare_b_value <= pair_write(compare_b_value, req.addr == ptmc_pkg::OFF_CMPB_HI,
                req.wdata);
    end

    // Compare A takes falling captures, or every capture when edge clear is off.
    // The same priority as compare B keeps both halves of a pulse measurement in step.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            compare_a_value <= ptmc_pkg::VAL_RESET;
        else if (cap_fall || (cap_rise && capture_clear_sel == ptmc_pkg::CAPCLR_RESET))
            compare_a_value <= count;
        else if (req.wr && (req.addr == ptmc_pkg::OFF_CMPA_LO || req.addr == ptmc_pkg::OFF_CMPA_HI))
            compare_a_value <= pair_write(compare_a_value, req.addr == ptmc_pkg::OFF_CMPA_HI,
                req.wdata);
    end

    // Period register.
    // The bytes land independently, so a running period briefly mixes old and new halves.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            period_value <= ptmc_pkg::VAL_RESET;
        else if (req.wr && (req.addr == ptmc_pkg::OFF_PER_LO || req.addr == ptmc_pkg::OFF_PER_HI))
            period_value <= pair_write(period_value, req.addr == ptmc_pkg::OFF_PER_HI, req.wdata);
    end

    // Edge flag records which edge caused the latest latch.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            latch_edge_flag <= 1'b0;
        else if (cap_rise)
            latch_edge_flag <= 1'b1;
        else if (cap_fall)
            latch_edge_flag <= 1'b0;
    end

    // Compare-mode output level; reset to initial level by counter_on rising.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            out_level <= 1'b0;
        else if (on_rise)
            out_level <= output_init_level;
        else if (op_mode_sel == ptmc_pkg::PTMC_COMPARE && match_a)
        begin
            // A set to the level already held is a no-change by construction.
            case (pin_function_sel)
                ptmc_pkg::PIN_01: out_level <= 1'b0;
                ptmc_pkg::PIN_10: out_level <= 1'b1;
                ptmc_pkg::PIN_11: out_level <= !out_level;
                default: out_level <= out_level;
            endcase
        end
    end

    // Output pin before polarity; the forced PWM codes hold a fixed level and ignore the duty.
    always_comb
    begin
        next_pin = out_level;
        if (op_mode_sel == ptmc_pkg::PTMC_PWM)
        begin
            case (pin_function_sel)
                ptmc_pkg::PIN_00: next_pin = !output_init_level;
                ptmc_pkg::PIN_01: next_pin = output_init_level;
                ptmc_pkg::PIN_10:
                    next_pin = (counter_on && count < compare_a_value) ? output_init_level : !output_init_level;
                default: next_pin = counter_on ? output_init_level : !output_init_level;
            endcase
        end
    end

    // Registered pin and enable; timer and capture modes release the pin.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timer_output_pin <= 1'b0;
            timer_output_pin_oe <= 1'b0;
        end
        else
        begin
            timer_output_pin <= next_pin ^ output_invert;
            timer_output_pin_oe <= (op_mode_sel == ptmc_pkg::PTMC_COMPARE)
                || (op_mode_sel == ptmc_pkg::PTMC_PWM);
        end
    end

    // Read data one cycle after the strobe; unmapped and unused bits read zero.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 8'h00;
        else if (req.rd)
        begin
            case (req.addr)
                ptmc_pkg::OFF_CONTROL: rdata <= {4'h0, counter_on, 3'h0};
                ptmc_pkg::OFF_MODE: rdata <= mode_reg;
                ptmc_pkg::OFF_CAPCLR: rdata <= {5'h00, capture_clear_sel, latch_edge_flag};
                ptmc_pkg::OFF_CNT_LO: rdata <= count[7:0];
                ptmc_pkg::OFF_CNT_HI: rdata <= {6'h00, count[9:8]};
                ptmc_pkg::OFF_CMPA_LO: rdata <= compare_a_value[7:0];
                ptmc_pkg::OFF_CMPA_HI: rdata <= {6'h00, compare_a_value[9:8]};
                ptmc_pkg::OFF_CMPB_LO: rdata <= compare_b_value[7:0];
                ptmc_pkg::OFF_CMPB_HI: rdata <= {6'h00, compare_b_value[9:8]};
                ptmc_pkg::OFF_PER_LO: rdata <= period_value[7:0];
                ptmc_pkg::OFF_PER_HI: rdata <= {6'h00, period_value[9:8]};
                default: rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end
endmodule
`default_nettype wire
